/* File: src/clock_mode_pkg.sv */
// Package of register map, field layout, timing counts and states of the clock and mode control.
package clock_mode_pkg;

    // ****************************************
    // Register bus
    // ****************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Printed offsets are word indexes; the byte address is four times the index.
    localparam logic [ADDR_W-1:0] OSC_MODE_INDEX = 12'h0ca;
    localparam logic [ADDR_W-1:0] MODE_STATUS_INDEX = 12'h0cb;
    localparam logic [ADDR_W-1:0] OSC_MODE_ADDR = 12'h328;
    localparam logic [ADDR_W-1:0] MODE_STATUS_ADDR = 12'h32c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Oscillator mode control fields
    // ****************************************
    localparam int FAST_STOP_BIT = 1;
    localparam int SLOW_SEL_BIT = 2;
    localparam int MODE_LSB = 3;
    localparam int MODE_MSB = 4;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_GREEN = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;

    // ****************************************
    // Status codes
    // ****************************************
    localparam logic [2:0] STAT_NORMAL = 3'h0;
    localparam logic [2:0] STAT_SLEEP = 3'h1;
    localparam logic [2:0] STAT_GREEN = 3'h2;
    localparam logic [2:0] STAT_SLOW = 3'h3;
    localparam logic [2:0] STAT_STARTUP = 3'h4;

    // ****************************************
    // Timing in oscillator periods
    // ****************************************
    localparam int FAST_OSC_HZ = 16000000;
    localparam int CONFIG_PERIODS = 2048;
    localparam int RESET_WARM_PERIODS = 2048;
    localparam int WAKE_WARM_PERIODS = 32;
    localparam int SLOW_CPU_DIV = 4;
    localparam int CPU_DIV_DEFAULT = 4;
    localparam int TIMER_W = 12;

    typedef enum logic [2:0] {
        ST_BOOT,
        ST_CONFIG,
        ST_WARMUP,
        ST_NORMAL,
        ST_SLOW,
        ST_GREEN,
        ST_SLEEP,
        ST_WAKE_WARM
    } state_t;

endpackage

/* File: src/period_timer_if.sv */
// Interface between the mode controller and its oscillator period counter.
`timescale 1ns/1ps
interface period_timer_if;
    logic start;
    logic [clock_mode_pkg::TIMER_W-1:0] target;
    logic tick;
    logic done;
    modport owner (output start, output target, output tick, input done);
    modport counter (input start, input target, input tick, output done);
endinterface

/* File: src/period_timer.sv */
// Counter of oscillator periods that reports when a loaded number of periods has passed.
`timescale 1ns/1ps
module period_timer (
    input wire logic clk,
    input wire logic rst_b,
    period_timer_if.counter tmr
);
    import clock_mode_pkg::*;

    logic busy;
    logic [TIMER_W-1:0] count;
    logic [TIMER_W-1:0] limit;
    logic done;
    wire last_tick = busy && tmr.tick && (count == limit);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            busy <= 1'b0;
            count <= '0;
            limit <= '0;
            done <= 1'b0;
        end else if (tmr.start) begin
            busy <= 1'b1;
            count <= '0;
            limit <= tmr.target - 1'b1;
            done <= 1'b0;
        end else begin
            done <= last_tick;
            if (last_tick) begin
                busy <= 1'b0;
            end
            if (busy && tmr.tick) begin
                count <= count + 1'b1;
            end
        end
    end

    assign tmr.done = done;

endmodule // period_timer

/* File: src/clock_mode_control.sv */
// Clock source and operating mode controller with an AXI4-Lite register slave.
//
// Function
// [RULE1] Fast oscillator, nominal 16 MHz, is the normal mode clock source.
// [RULE2] Slow oscillator clocks the watchdog and the slow mode system clock.
// [RULE3] Slow mode instruction rate is slow oscillator frequency divided by four.
// [RULE4] Slow oscillator stops only in sleep, or green with slow clock and no watchdog.
// [RULE5] No control bit stops the slow oscillator directly; only mode bits do.
// [RULE6] Bit 1 stops the fast oscillator when set; slow oscillator keeps running.
// [RULE7] Bit 2 selects fast clock when 0, slow oscillator when 1.
// [RULE8] Mode field bits 4:3: 00 normal, 01 sleep, 10 green, 11 reserved.
// [RULE9] After power-up wait 2048 slow oscillator periods of configuration.
// [RULE10] After any reset hold execution for 2048 fast oscillator periods of warm-up.
// [RULE11] Sleep wake-up waits 32 fast oscillator periods before normal execution.
// [RULE12] After reset release or sleep wake-up the device runs in normal mode.
// [RULE13] Slow mode never stops the fast oscillator by itself; only the stop bit does.
// [RULE14] Green wake-up returns to normal or slow, whichever green was entered from; the code picks by the slow clock select bit at wake-up.
// [RULE15] Writing the sleep request enters sleep; wake-up clears it.
// [RULE16] Sleep stops all oscillators, execution, timers and interrupts.
// [RULE17] Sleep exits only on port 0 or enabled port 1 level change, or reset.
// [RULE18] Fast stop in normal mode leaves no clock; behaves as sleep until port change.
// [RULE19] Green stops execution; timers follow their enables, PWM outputs stay active.
// [RULE20] Green keeps only basic and capture timer interrupts plus external interrupts.
// [RULE21] Green wakes on port change, basic or capture timer, comparator, or reset.
// [RULE22] Watchdog runs by build option alike in every mode.
// [RULE23] Normal instruction rate is fast oscillator divided by build divisor 1 to 16.
// [RULE24] Writing the green request enters green; wake-up clears it.
// [RULE25] Reserved mode code 11 causes no mode change.
`timescale 1ns/1ps
module clock_mode_control #(
    parameter int CPU_DIV = clock_mode_pkg::CPU_DIV_DEFAULT,
    parameter bit WATCHDOG_ON = 1'b1,
    parameter int CONFIG_PERIODS = clock_mode_pkg::CONFIG_PERIODS,
    parameter int RESET_WARM_PERIODS = clock_mode_pkg::RESET_WARM_PERIODS,
    parameter int WAKE_WARM_PERIODS = clock_mode_pkg::WAKE_WARM_PERIODS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [clock_mode_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [clock_mode_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [clock_mode_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [clock_mode_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cold_start,
    input wire logic fast_osc_tick,
    input wire logic slow_osc_tick,
    input wire logic [7:0] port0_level,
    input wire logic [7:0] port1_level,
    input wire logic [7:0] port1_wake_enable,
    input wire logic basic_timer_event,
    input wire logic capture_timer_event,
    input wire logic comparator_wake,
    input wire logic [3:0] timer_enable,
    output logic fast_osc_enable,
    output logic slow_osc_enable,
    output logic slow_clock_active,
    output logic cpu_run,
    output logic instr_tick,
    output logic [3:0] timer_run,
    output logic pwm_output_active,
    output logic wake_timer_irq_active,
    output logic other_irq_active,
    output logic external_irq_active,
    output logic watchdog_run
);
    import clock_mode_pkg::*;

    // ****************************************
    // Oscillator mode control register
    // ****************************************
    logic fast_osc_stop;
    logic slow_clock_select;
    logic sleep_request;
    logic green_request;
    state_t state;
    state_t next_state;
    period_timer_if tmr ();

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire wr_fire = aw_held && w_held && !s_axi_bvalid;
    wire wr_hit_osc = (aw_addr == OSC_MODE_ADDR);
    wire wr_hit_stat = (aw_addr == MODE_STATUS_ADDR);
    wire osc_write = wr_fire && wr_hit_osc && w_strb[0];
    wire [1:0] wr_mode = w_data[MODE_MSB:MODE_LSB];
    wire rd_fire = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_hit_osc || wr_hit_stat) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Read decode
    // ****************************************
    logic [2:0] status_code;
    wire [DATA_W-1:0] osc_word = {27'h000_0000, green_request, sleep_request, slow_clock_select,
                                  fast_osc_stop, 1'b0};
    wire [DATA_W-1:0] stat_word = {26'h000_0000, slow_osc_enable, fast_osc_enable, cpu_run, status_code};
    wire rd_hit_osc = (s_axi_araddr == OSC_MODE_ADDR);
    wire rd_hit_stat = (s_axi_araddr == MODE_STATUS_ADDR);
    wire [DATA_W-1:0] rd_word = rd_hit_osc ? osc_word : (rd_hit_stat ? stat_word : '0);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rd_hit_osc || rd_hit_stat) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // Wake-up detection
    // ****************************************
    logic [7:0] port0_snap;
    logic [7:0] port1_snap;
    wire entering_idle = (next_state != state) && (next_state == ST_SLEEP || next_state == ST_GREEN);
    // Port 1 pins join the wake-up only where their enable is set.
    wire port_change = (|(port0_level ^ port0_snap)) ||
                       (|((port1_level ^ port1_snap) & port1_wake_enable)); // [RULE17]
    // Green also wakes on timer and comparator events.
    wire green_wake = port_change || basic_timer_event || capture_timer_event || comparator_wake; // [RULE21]

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            port0_snap <= '0;
            port1_snap <= '0;
        end else if (entering_idle) begin
            port0_snap <= port0_level;
            port1_snap <= port1_level;
        end
    end

    // ****************************************
    // Mode sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        case (state)
            ST_BOOT: begin
                next_state = cold_start ? ST_CONFIG : ST_WARMUP; // [RULE9] [RULE10]
            end
            ST_CONFIG: begin
                if (tmr.done) begin
                    next_state = ST_WARMUP;
                end
            end
            ST_WARMUP: begin
                if (tmr.done) begin
                    next_state = ST_NORMAL; // [RULE12]
                end
            end
            ST_NORMAL: begin
                if (sleep_request) begin
                    next_state = ST_SLEEP; // [RULE15]
                end else if (green_request) begin
                    next_state = ST_GREEN; // [RULE24]
                end else if (fast_osc_stop) begin
                    next_state = ST_SLEEP; // [RULE18]
                end else if (slow_clock_select) begin
                    next_state = ST_SLOW; // [RULE7]
                end
            end
            ST_SLOW: begin
                if (sleep_request) begin
                    next_state = ST_SLEEP;
                end else if (green_request) begin
                    next_state = ST_GREEN;
                end else if (!slow_clock_select) begin
                    next_state = ST_NORMAL;
                end
            end
            ST_GREEN: begin
                if (green_wake) begin
                    next_state = slow_clock_select ? ST_SLOW : ST_NORMAL; // [RULE14]
                end
            end
            ST_SLEEP: begin
                if (port_change) begin
                    next_state = ST_WAKE_WARM; // [RULE17]
                end
            end
            ST_WAKE_WARM: begin
                if (tmr.done) begin
                    next_state = ST_NORMAL; // [RULE11] [RULE12]
                end
            end
            default: begin
                next_state = ST_BOOT;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= ST_BOOT;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Configuration and warm-up timing
    // ****************************************

    wire state_change = (next_state != state);
    assign tmr.start = state_change &&
                       (next_state == ST_CONFIG || next_state == ST_WARMUP || next_state == ST_WAKE_WARM);
    assign tmr.target = (next_state == ST_CONFIG) ? TIMER_W'(CONFIG_PERIODS) : // [RULE9]
                        (next_state == ST_WARMUP) ? TIMER_W'(RESET_WARM_PERIODS) : // [RULE10]
                        TIMER_W'(WAKE_WARM_PERIODS); // [RULE11]
    // Configuration runs on slow oscillator periods, both warm-ups on fast ones.
    assign tmr.tick = (state == ST_CONFIG) ? slow_osc_tick : fast_osc_tick;

    period_timer period_timer_inst (
        .clk(clk),
        .rst_b(rst_b),
        .tmr(tmr)
    );

    // ****************************************
    // Register update
    // ****************************************
    wire sleep_wake = (state == ST_SLEEP) && (next_state == ST_WAKE_WARM);
    wire green_leave = (state == ST_GREEN) && (next_state != ST_GREEN);
    // The reserved code is dropped so the block stays in its present mode.
    wire mode_accept = (wr_mode != MODE_RESERVED); // [RULE25]

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fast_osc_stop <= 1'b0;
            slow_clock_select <= 1'b0;
            sleep_request <= 1'b0;
            green_request <= 1'b0;
        end else if (osc_write) begin
            // A software write in the same cycle as a wake-up clear takes priority.
            fast_osc_stop <= w_data[FAST_STOP_BIT]; // [RULE6] [RULE13]
            slow_clock_select <= w_data[SLOW_SEL_BIT]; // [RULE7]
            if (mode_accept) begin
                sleep_request <= (wr_mode == MODE_SLEEP); // [RULE8] [RULE15]
                green_request <= (wr_mode == MODE_GREEN); // [RULE8] [RULE24]
            end
        end else if (sleep_wake) begin
            // Wake from sleep returns to a clocked normal mode.
            sleep_request <= 1'b0; // [RULE15]
            fast_osc_stop <= 1'b0; // [RULE18]
            slow_clock_select <= 1'b0; // [RULE12]
        end else if (green_leave) begin
            green_request <= 1'b0; // [RULE24]
        end
    end

    // ****************************************
    // Instruction rate divider
    // ****************************************
    wire executing = (state == ST_NORMAL) || (state == ST_SLOW);
    wire div_src = (state == ST_NORMAL) ? fast_osc_tick : (state == ST_SLOW) ? slow_osc_tick : 1'b0; // [RULE1] [RULE2]
    wire [3:0] div_limit = (state == ST_SLOW) ? 4'(SLOW_CPU_DIV - 1) : 4'(CPU_DIV - 1); // [RULE3] [RULE23]
    logic [3:0] div_count;
    wire div_last = div_src && (div_count == div_limit);

    always_ff @(posedge clk) begin
        if (!rst_b || !executing) begin
            div_count <= '0;
            instr_tick <= 1'b0;
        end else begin
            instr_tick <= div_last;
            if (div_src) begin
                div_count <= div_last ? 4'h0 : div_count + 4'h1;
            end
        end
    end

    // ****************************************
    // Oscillator, timer and interrupt gating
    // ****************************************
    wire in_idle_green = (state == ST_GREEN);
    wire in_sleep = (state == ST_SLEEP);
    wire timers_live = executing || in_idle_green;
    logic next_fast_en;
    logic next_slow_en;

    always_comb begin
        case (state)
            ST_NORMAL, ST_WARMUP, ST_WAKE_WARM: begin
                next_fast_en = 1'b1; // [RULE1]
            end
            ST_SLOW, ST_GREEN: begin
                next_fast_en = !fast_osc_stop; // [RULE13] [RULE19]
            end
            default: begin
                next_fast_en = 1'b0; // [RULE16]
            end
        endcase
        // Only the mode, the slow clock select and the watchdog option decide the slow oscillator; no bit of its own exists.
        next_slow_en = !(in_sleep || (in_idle_green && slow_clock_select && !WATCHDOG_ON)); // [RULE4] [RULE5]
    end

    always_comb begin
        case (state)
            ST_NORMAL: status_code = STAT_NORMAL;
            ST_SLOW: status_code = STAT_SLOW;
            ST_GREEN: status_code = STAT_GREEN;
            ST_SLEEP: status_code = STAT_SLEEP;
            default: status_code = STAT_STARTUP;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fast_osc_enable <= 1'b0;
            slow_osc_enable <= 1'b1;
            slow_clock_active <= 1'b0;
            cpu_run <= 1'b0;
            timer_run <= '0;
            pwm_output_active <= 1'b0;
            wake_timer_irq_active <= 1'b0;
            other_irq_active <= 1'b0;
            external_irq_active <= 1'b0;
            watchdog_run <= 1'b0;
        end else begin
            fast_osc_enable <= next_fast_en;
            slow_osc_enable <= next_slow_en;
            slow_clock_active <= (state == ST_SLOW) || (in_idle_green && slow_clock_select); // [RULE2]
            cpu_run <= executing; // [RULE16] [RULE19]
            timer_run <= {4{timers_live}} & timer_enable; // [RULE16] [RULE19]
            pwm_output_active <= timers_live; // [RULE19]
            wake_timer_irq_active <= timers_live; // [RULE20]
            other_irq_active <= executing; // [RULE20]
            external_irq_active <= timers_live; // [RULE16] [RULE20]
            watchdog_run <= WATCHDOG_ON; // [RULE22]
        end
    end

endmodule // clock_mode_control

/* File: bench/clock_mode_control_checker.sv */
// Concurrent checks on the ports of the clock and mode controller.
`timescale 1ns/1ps
module clock_mode_control_checker #(
    parameter bit WATCHDOG_ON = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic fast_osc_tick,
    input wire logic slow_osc_tick,
    input wire logic slow_osc_enable,
    input wire logic slow_clock_active,
    input wire logic cpu_run,
    input wire logic instr_tick,
    input wire logic [3:0] timer_run,
    input wire logic pwm_output_active,
    input wire logic wake_timer_irq_active,
    input wire logic other_irq_active,
    input wire logic external_irq_active,
    input wire logic watchdog_run
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ****************************************
    // Properties
    // ****************************************
    sequence resp_held;
        s_axi_bvalid && $stable(s_axi_bresp);
    endsequence
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> resp_held) else $error("bresp dropped early");
    stopped_no_tick_a: assert property (!cpu_run |-> !instr_tick) else $error("tick while halted");
    slow_tick_rate_a: assert property (instr_tick && slow_clock_active && cpu_run |-> $past(slow_osc_tick))
        else $error("slow tick without slow period");
    fast_tick_rate_a: assert property (instr_tick && !slow_clock_active && cpu_run
        |-> $past(fast_osc_tick)) else $error("fast tick without fast period");
    slow_stop_halt_a: assert property (!slow_osc_enable |-> !cpu_run && !other_irq_active)
        else $error("slow oscillator off while running");
    sleep_timers_a: assert property (!pwm_output_active |-> timer_run == 4'h0 && !external_irq_active)
        else $error("timers alive in sleep");
    green_irqs_a: assert property (pwm_output_active && !cpu_run
        |-> wake_timer_irq_active && !other_irq_active) else $error("green interrupt gating wrong");
    irq_needs_run_a: assert property (other_irq_active |-> cpu_run && external_irq_active)
        else $error("interrupts outside run");
    watchdog_opt_a: assert property ($past(rst_b) |-> watchdog_run == WATCHDOG_ON)
        else $error("watchdog not by option");
endmodule // clock_mode_control_checker
bind clock_mode_control clock_mode_control_checker #(.WATCHDOG_ON(WATCHDOG_ON)) clock_mode_control_checker_inst (
    .clk, .rst_b, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .fast_osc_tick, .slow_osc_tick,
    .slow_osc_enable, .slow_clock_active, .cpu_run, .instr_tick, .timer_run, .pwm_output_active,
    .wake_timer_irq_active, .other_irq_active, .external_irq_active, .watchdog_run);

/* File: bench/clock_mode_control_test.sv */
// Self-checking testbench of the clock and mode controller.
`timescale 1ns/1ps
module clock_mode_control_test;
    import clock_mode_pkg::*;
    logic clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic cold = 1, ftick = 0, stick = 0, bev = 0, cev = 0, cmp = 0;
    logic [7:0] p0 = 0, p1 = 0, p1en = 0;
    logic [3:0] ten = 0;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    int miscompares = 0, n_checks = 0;
    always #2.5 clk = ~clk;
    clock_mode_control #(.CPU_DIV(2), .CONFIG_PERIODS(8), .RESET_WARM_PERIODS(8), .WAKE_WARM_PERIODS(4))
    clock_mode_control_inst (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cold_start(cold),
        .fast_osc_tick(ftick), .slow_osc_tick(stick), .port0_level(p0), .port1_level(p1),
        .port1_wake_enable(p1en), .basic_timer_event(bev), .capture_timer_event(cev), .comparator_wake(cmp),
        .timer_enable(ten), .fast_osc_enable(), .slow_osc_enable(), .slow_clock_active(), .cpu_run(),
        .instr_tick(), .timer_run(), .pwm_output_active(), .wake_timer_irq_active(), .other_irq_active(),
        .external_irq_active(), .watchdog_run());
    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(string nm, logic [31:0] seen, logic [31:0] expv);
        n_checks++;
        if (seen !== expv) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, expv, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Oscillator periods arrive at random so no count can line up with the bus by luck.
    always @(posedge clk) begin
        ftick <= ($urandom % 2) == 0;
        stick <= ($urandom % 4) == 0;
        ten <= $urandom;
    end
    // Each result that appears on the bus is matched against the oldest noted expectation.
    always @(posedge clk) begin
        if (bvalid && bready) begin
            e = exp_q.pop_front();
            check("bresp", {30'h0, bresp}, {30'h0, e[33:32]});
        end
        if (rvalid && rready) begin
            e = exp_q.pop_front();
            check("rresp", {30'h0, rresp}, {30'h0, e[33:32]});
            check("rdata", rdata, e[31:0]);
        end
    end
    task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] r = RESP_OKAY);
        exp_q.push_back({r, 32'h0});
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        repeat (3) @(posedge clk);
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] d, logic [1:0] r = RESP_OKAY);
        exp_q.push_back({r, d});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
    endtask
    task automatic wait_run();
        int n;
        n = 0;
        while (clock_mode_control_inst.cpu_run !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        check("run", {31'h0, clock_mode_control_inst.cpu_run}, 32'h1);
        repeat (3) @(posedge clk);
    endtask
    task automatic pulse(int k);
        @(posedge clk);
        {cmp, cev, bev} <= 3'b001 << k;
        @(posedge clk);
        {cmp, cev, bev} <= 3'h0;
        repeat (4) @(posedge clk);
    endtask
    task automatic boot(logic c);
        cold <= c;
        rst_b <= 0;
        repeat (16) @(posedge clk);
        rst_b <= 1;
        repeat (8) @(posedge clk);
        check("run", {31'h0, clock_mode_control_inst.cpu_run}, 32'h0);
        wait_run();
        rd(OSC_MODE_ADDR, 32'h0000_0000);
        rd(MODE_STATUS_ADDR, 32'h0000_0038);
    endtask
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        void'($urandom(56776));
        p0 <= $urandom;
        boot(1);
        wr(OSC_MODE_ADDR, 32'h0000_0004);
        rd(MODE_STATUS_ADDR, 32'h0000_003b);
        wr(OSC_MODE_ADDR, 32'h0000_0006);
        rd(MODE_STATUS_ADDR, 32'h0000_002b);
        wr(OSC_MODE_ADDR, 32'h0000_001c);
        rd(OSC_MODE_ADDR, 32'h0000_0004);
        wr(OSC_MODE_ADDR, 32'h0000_0014);
        rd(MODE_STATUS_ADDR, 32'h0000_0032);
        pulse(0);
        rd(MODE_STATUS_ADDR, 32'h0000_003b);
        rd(OSC_MODE_ADDR, 32'h0000_0004);
        wr(OSC_MODE_ADDR, 32'h0000_0000);
        for (int k = 1; k < 3; k++) begin
            wr(OSC_MODE_ADDR, 32'h0000_0010);
            pulse(k);
            rd(MODE_STATUS_ADDR, 32'h0000_0038);
        end
        wr(OSC_MODE_ADDR, 32'h0000_0008);
        rd(MODE_STATUS_ADDR, 32'h0000_0001);
        p1 <= ~p1;
        pulse(0);
        rd(MODE_STATUS_ADDR, 32'h0000_0001);
        p0 <= ~p0;
        wait_run();
        rd(OSC_MODE_ADDR, 32'h0000_0000);
        rd(MODE_STATUS_ADDR, 32'h0000_0038);
        wr(OSC_MODE_ADDR, 32'h0000_0002);
        rd(MODE_STATUS_ADDR, 32'h0000_0001);
        p1en <= 8'h01;
        p1 <= p1 ^ 8'h01;
        wait_run();
        wr(12'h100, 32'h0000_0008, RESP_SLVERR);
        rd(12'h100, 32'h0000_0000, RESP_SLVERR);
        boot(0);
        finish_test();
    end
endmodule // clock_mode_control_test
